/* File: tsw_pkg.sv */
// shared constants for the two stage watchdog and its controller
package tsw_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int          TSW_CNT_W        = 32;
   localparam int          TSW_ADDR_W       = 12;
   // ---------------------------------------------------------------
   // watchdog register offsets, seen through the link
   // ---------------------------------------------------------------
   localparam logic [11:0] TSW_OFF_RELOAD   = 12'h000;
   localparam logic [11:0] TSW_OFF_VALUE    = 12'h004;
   localparam logic [11:0] TSW_OFF_CONTROL  = 12'h008;
   localparam logic [11:0] TSW_OFF_IRQ_CLR  = 12'h00C;
   localparam logic [11:0] TSW_OFF_RAW      = 12'h010;
   localparam logic [11:0] TSW_OFF_MASKED   = 12'h014;
   localparam logic [11:0] TSW_OFF_LOCK     = 12'hC00;
   // ---------------------------------------------------------------
   // fields, key and reset values
   // ---------------------------------------------------------------
   localparam int          TSW_BIT_EN       = 0;
   localparam int          TSW_BIT_RESET_OUTPUT_ENABLE    = 1;
   localparam logic [31:0] TSW_UNLOCK_KEY   = 32'h1ACCE551;
   localparam logic [31:0] TSW_RELOAD_RST   = 32'hFFFFFFFF;
   localparam logic [31:0] TSW_ZERO         = 32'h00000000;
   localparam logic [31:0] TSW_ONE          = 32'h00000001;
   // ---------------------------------------------------------------
   // controller registers on apb
   // ---------------------------------------------------------------
   localparam logic [7:0]  TSW_APB_ADDR     = 8'h00;
   localparam logic [7:0]  TSW_APB_WDATA    = 8'h04;
   localparam logic [7:0]  TSW_APB_GO       = 8'h08;
   localparam logic [7:0]  TSW_APB_STATUS   = 8'h0C;
   localparam logic [7:0]  TSW_APB_RDATA    = 8'h10;
   localparam logic [7:0]  TSW_APB_GATE     = 8'h14;
   localparam int          TSW_GO_WRITE_BIT = 16;
   localparam int          TSW_ST_BUSY      = 0;
   localparam int          TSW_ST_IRQ       = 1;
   localparam int          TSW_ST_SYSRST    = 2;
   localparam int          TSW_ST_GATE      = 3;
endpackage : tsw_pkg

/* File: tsw_link_if.sv */
// link between the watchdog and the controller that drives it
interface tsw_link_if;
   logic        gate_on;
   logic        req;
   logic        we;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        ack;
   logic        irq;
   logic        sys_reset;

   modport dev (input gate_on, input req, input we, input addr, input wdata,
                output rdata, output ack, output irq, output sys_reset);
   modport ctl (output gate_on, output req, output we, output addr, output wdata,
                input rdata, input ack, input irq, input sys_reset);
endinterface : tsw_link_if

/* File: tsw_device.sv */
// two stage watchdog: down counter, interrupt, reset output and lock
// Function
// [RULE_01] enabled 32-bit counter times out at zero
// [RULE_02] first time-out reloads counter, keeps counting
// [RULE_03] second time-out uncleared with reset enabled: reset
// [RULE_04] cleared before second time-out: reload, no reset
// [RULE_05] reload write loads counter at once
// [RULE_06] reload write leaves pending interrupt alone
// [RULE_07] software clears interrupt only via clear port
// [RULE_08] enabling presets counter from reload value
// [RULE_09] any lock write locks the module
// [RULE_10] only the key value unlocks
// [RULE_11] software order: reload, reset enable, enable
// [RULE_12] software gates the clock on before use
// [RULE_13] after enable, control writes ignored until reset
// [RULE_14] reload of zero raises interrupt immediately
// [RULE_15] clear write clears interrupt and reloads counter
// [RULE_16] masked status is raw AND enable
// [RULE_17] locked: only lock register accepts writes
// [RULE_18] hardware reset: stopped, outputs low, unlocked
//
// The address map and register access over APB were chosen for this implementation.
module tsw_device
   import tsw_pkg::*;
#(
   parameter int CNT_W = TSW_CNT_W
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   tsw_link_if.dev               link,
   output logic                  o_irq,
   output logic                  o_sys_reset,
   output logic [CNT_W-1:0]      o_count
);

   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   generate
      if (CNT_W != TSW_CNT_W) begin : g_bad_width
         $error("tsw_device: counter must be 32 bits wide");
      end
      if (TSW_BIT_EN == TSW_BIT_RESET_OUTPUT_ENABLE) begin : g_bad_bits
         $error("tsw_device: control bits must differ");
      end
   endgenerate

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] reload;
      logic [31:0] count;
      logic        enable;
      logic        reset_output_enable;
      logic        raw;
      logic        locked;
      logic        sys_reset;
      logic        ack;
      logic [31:0] rdata;
   } tsw_dev_state_type;

   tsw_dev_state_type s;
   tsw_dev_state_type next_s;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic tsw_hit(input logic [11:0] a, input logic [11:0] off);
      tsw_hit = (a == off);
   endfunction : tsw_hit

   // the interrupt pin and its status bit share one definition
   function automatic logic tsw_masked(input tsw_dev_state_type st);
      tsw_masked = st.raw & st.enable; // RULE_16
   endfunction : tsw_masked

   // read view of the registers; unmapped offsets read as zero
   function automatic logic [31:0] tsw_read_word(input tsw_dev_state_type st,
                                                 input logic [11:0]       a);
      logic [31:0] w;
      w = TSW_ZERO;
      case (a)
         TSW_OFF_RELOAD:  w = st.reload;
         TSW_OFF_VALUE:   w = st.count;
         TSW_OFF_CONTROL: begin
            w[TSW_BIT_EN]    = st.enable;
            w[TSW_BIT_RESET_OUTPUT_ENABLE] = st.reset_output_enable;
         end
         TSW_OFF_RAW:     w[0] = st.raw;
         TSW_OFF_MASKED:  w[0] = tsw_masked(st); // RULE_16
         TSW_OFF_LOCK:    w[0] = st.locked;
         default:         w = TSW_ZERO;
      endcase
      tsw_read_word = w;
   endfunction : tsw_read_word

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   logic wr;
   logic tick;
   logic timeout;
   logic second_timeout;
   logic writable;
   logic wr_lock;
   logic wr_reload;
   logic wr_control;
   logic wr_clear;

   always_comb begin
      // a gated clock means the block sees nothing from software
      wr             = link.req & link.we & link.gate_on; // RULE_12
      // a gated block also holds its count
      tick           = s.enable & link.gate_on;
      timeout        = tick & (s.count == TSW_ZERO); // RULE_01
      second_timeout = timeout & s.raw & s.reset_output_enable; // RULE_03
      // the lock register stays writable so the key can get in
      writable       = ~s.locked; // RULE_17
      wr_lock        = wr & tsw_hit(link.addr, TSW_OFF_LOCK);
      wr_reload      = wr & writable & tsw_hit(link.addr, TSW_OFF_RELOAD);
      // once enabled the control word is frozen until reset
      wr_control     = wr & writable & ~s.enable // RULE_13
                       & tsw_hit(link.addr, TSW_OFF_CONTROL);
      // clearing also works while disabled, to drop a stale flag
      wr_clear       = wr & writable & tsw_hit(link.addr, TSW_OFF_IRQ_CLR);
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s     = s;
      next_s.ack = 1'b0;

      // the zero count lasts one cycle, so a period is reload plus one
      if (tick) begin
         if (timeout) begin
            next_s.count = s.reload; // RULE_02
            if (second_timeout) begin
               next_s.sys_reset = 1'b1; // RULE_03
            end
            next_s.raw = 1'b1; // RULE_01
         end else begin
            next_s.count = s.count - TSW_ONE;
         end
      end

      if (wr_lock) begin
         // any value locks, only the key unlocks
         next_s.locked = (link.wdata != TSW_UNLOCK_KEY); // RULE_09 RULE_10
      end
      if (wr_reload) begin
         next_s.reload = link.wdata;
         next_s.count  = link.wdata; // RULE_05
         // raw is kept as is unless the new value is zero
         if (link.wdata == TSW_ZERO) begin // RULE_06
            next_s.raw = 1'b1; // RULE_14
         end
      end
      if (wr_control) begin
         next_s.reset_output_enable  = link.wdata[TSW_BIT_RESET_OUTPUT_ENABLE];
         next_s.enable = link.wdata[TSW_BIT_EN];
         if (link.wdata[TSW_BIT_EN]) begin
            next_s.count = s.reload; // RULE_08
         end
      end
      if (wr_clear) begin
         // a time-out in the same cycle keeps the flag set
         next_s.raw   = timeout; // RULE_15 RULE_04
         next_s.count = s.reload; // RULE_15 RULE_04
      end

      if (link.req) begin
         next_s.ack   = 1'b1;
         // a gated block answers every read with zero
         next_s.rdata = link.gate_on ? tsw_read_word(s, link.addr) : TSW_ZERO;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         // counter and reload come up at full scale, stopped and unlocked
         s.reload    <= TSW_RELOAD_RST; // RULE_18
         s.count     <= TSW_RELOAD_RST;
         s.enable    <= 1'b0;
         s.reset_output_enable     <= 1'b0;
         s.raw       <= 1'b0;
         s.locked    <= 1'b0;
         s.sys_reset <= 1'b0;
         s.ack       <= 1'b0;
         s.rdata     <= TSW_ZERO;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // the interrupt line follows the masked status
   assign o_irq          = tsw_masked(s); // RULE_16
   // sticky: only i_rst_n drops it, so a hung system stays held
   assign o_sys_reset    = s.sys_reset;
   assign o_count        = s.count;
   // the link carries the same lines so the controller can report them
   assign link.irq       = tsw_masked(s);
   assign link.sys_reset = s.sys_reset;
   assign link.ack       = s.ack;
   assign link.rdata     = s.rdata;

endmodule : tsw_device

/* File: tsw_ctrl.sv */
// controller: apb slave that issues watchdog accesses over the link
module tsw_ctrl
   import tsw_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   tsw_link_if.ctl          link
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [11:0] addr;
      logic        we;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic        busy;
      logic        req;
      logic        gate;
      logic [31:0] prdata;
   } tsw_ctl_state_type;

   tsw_ctl_state_type s;
   tsw_ctl_state_type next_s;

   logic apb_wr;
   logic apb_setup;

   always_comb begin
      next_s     = s;
      next_s.req = 1'b0;
      apb_wr     = i_psel & i_penable & i_pwrite;
      apb_setup  = i_psel & ~i_penable;

      if (s.busy && link.ack) begin
         next_s.busy  = 1'b0;
         next_s.rdata = link.rdata;
      end

      if (apb_wr) begin
         case (i_paddr)
            TSW_APB_ADDR: begin
               next_s.addr = i_pwdata[TSW_ADDR_W-1:0];
               next_s.we   = i_pwdata[TSW_GO_WRITE_BIT];
            end
            TSW_APB_WDATA: next_s.wdata = i_pwdata;
            TSW_APB_GO: begin
               // refused while busy or while the watchdog clock is off
               if (!s.busy && s.gate) begin // RULE_12
                  next_s.req  = 1'b1;
                  next_s.busy = 1'b1;
               end
            end
            TSW_APB_GATE:  next_s.gate = i_pwdata[0];
            default:       next_s.gate = s.gate;
         endcase
      end

      // read data is captured in setup so it comes from a flop
      if (apb_setup) begin
         next_s.prdata = TSW_ZERO;
         case (i_paddr)
            TSW_APB_ADDR: begin
               next_s.prdata[TSW_ADDR_W-1:0]   = s.addr;
               next_s.prdata[TSW_GO_WRITE_BIT] = s.we;
            end
            TSW_APB_WDATA:  next_s.prdata = s.wdata;
            TSW_APB_STATUS: begin
               next_s.prdata[TSW_ST_BUSY]   = s.busy;
               next_s.prdata[TSW_ST_IRQ]    = link.irq;
               next_s.prdata[TSW_ST_SYSRST] = link.sys_reset;
               next_s.prdata[TSW_ST_GATE]   = s.gate;
            end
            TSW_APB_RDATA:  next_s.prdata = s.rdata;
            TSW_APB_GATE:   next_s.prdata[0] = s.gate;
            default:        next_s.prdata = TSW_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s.addr   <= TSW_OFF_RELOAD;
         s.we     <= 1'b0;
         s.wdata  <= TSW_ZERO;
         s.rdata  <= TSW_ZERO;
         s.busy   <= 1'b0;
         s.req    <= 1'b0;
         s.gate   <= 1'b0;
         s.prdata <= TSW_ZERO;
      end else begin
         s <= next_s;
      end
   end

   assign o_prdata     = s.prdata;
   assign o_pready     = 1'b1;
   assign o_pslverr    = 1'b0;
   assign link.gate_on = s.gate;
   assign link.req     = s.req;
   assign link.we      = s.we;
   assign link.addr    = s.addr;
   assign link.wdata   = s.wdata;

endmodule : tsw_ctrl

/* File: tsw_link_assertions.sv */
// checker for the link between the watchdog and its controller
module tsw_link_assertions
   import tsw_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        gate_on,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic [31:0] rdata,
   input  wire logic        ack,
   input  wire logic        irq,
   input  wire logic        sys_reset
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic locked;
   // shadow of the lock, so that a refused clear is not flagged
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) locked <= 1'h0;
      else if (req && we && gate_on && addr == TSW_OFF_LOCK) locked <= wdata != TSW_UNLOCK_KEY;
   end
   sequence s_acked; ##1 ack; endsequence
   sequence s_clear; req && we && gate_on && !locked && addr == TSW_OFF_IRQ_CLR; endsequence
   AST_ACK_NEXT:
      assert property (req |-> s_acked) else $error("request without ack");
   AST_ACK_CAUSE:
      assert property (ack |-> $past(req)) else $error("ack without request");
   AST_RST_CLEAN:
      assert property ($rose(i_rst_n) |-> !irq && !sys_reset && !ack) else $error("reset state");
   AST_SYSRST_HOLD:
      assert property (sys_reset |=> sys_reset) else $error("system reset dropped");
   AST_SYSRST_CAUSE:
      assert property ($rose(sys_reset) |-> $past(irq)) else $error("reset without interrupt");
   AST_GATE_READ:
      assert property (req && !gate_on |=> rdata == 32'h00000000) else $error("gated read");
   AST_REQ_GATED:
      assert property (req |-> gate_on) else $error("request while clock gated");
   AST_CLR_DROPS:
      assert property (s_clear |=> !irq) else $error("clear left interrupt");
   AST_LOAD_KEEPS:
      assert property (irq && req && we && addr == TSW_OFF_RELOAD |=> irq)
         else $error("reload cleared interrupt");
   AST_MASKED_READ:
      assert property (req && !we && gate_on && addr == TSW_OFF_MASKED |=> rdata[0] == $past(irq))
         else $error("masked status wrong");
endmodule : tsw_link_assertions

/* File: tb.sv */
// testbench: watchdog and controller joined by the link, driven over apb
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb
   import tsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, irq, sys_rst;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, cnt, rd;
   int          err_total, n_checks, n;
   tsw_link_if link ();
   tsw_device tsw_device_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link), .o_irq(irq),
      .o_sys_reset(sys_rst), .o_count(cnt));
   tsw_ctrl tsw_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .link(link));
   tsw_link_assertions tsw_link_assertions_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .gate_on(link.gate_on), .req(link.req), .we(link.we), .addr(link.addr),
      .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .irq(link.irq),
      .sys_reset(link.sys_reset));
   // ---------------------------------------------------------------
   // bus, reset and report tasks
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_clk);
      penable <= 1'h1;
      do @(posedge i_clk); while (pready !== 1'h1);
      rd = prdata;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge i_clk);
   endtask : apb
   // one watchdog access; the link answer lands in rd
   task automatic lk(input logic w, input logic [11:0] off, input logic [31:0] d);
      apb(1'h1, TSW_APB_ADDR, {15'h0000, w, 4'h0, off});
      apb(1'h1, TSW_APB_WDATA, d);
      apb(1'h1, TSW_APB_GO, TSW_ZERO);
      do apb(1'h0, TSW_APB_STATUS, TSW_ZERO); while (rd[TSW_ST_BUSY] !== 1'h0);
      apb(1'h0, TSW_APB_RDATA, TSW_ZERO);
   endtask : lk
   task automatic hw_reset();
      i_rst_n <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'h1;
      @(posedge i_clk);
   endtask : hw_reset
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   // ---------------------------------------------------------------
   // clock, watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      i_clk = 1'h0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      #200000;
      err_total++;
      test_done();
   end
   initial begin
      i_rst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = TSW_ZERO;
      err_total = 0;
      n_checks = 0;
      hw_reset();
      apb(1'h0, TSW_APB_STATUS, TSW_ZERO);
      `CHK(rd[TSW_ST_GATE], 1'h0)
      apb(1'h1, TSW_APB_GATE, TSW_ONE);
      lk(1'h0, TSW_OFF_RELOAD, TSW_ZERO); `CHK(rd, TSW_RELOAD_RST)
      lk(1'h0, TSW_OFF_VALUE, TSW_ZERO); `CHK(rd, TSW_RELOAD_RST)
      lk(1'h0, TSW_OFF_CONTROL, TSW_ZERO); `CHK(rd, TSW_ZERO)
      lk(1'h0, TSW_OFF_LOCK, TSW_ZERO); `CHK(rd, TSW_ZERO)
      lk(1'h0, 12'h418, TSW_ZERO); `CHK(rd, TSW_ZERO)
      lk(1'h1, TSW_OFF_RELOAD, 32'h00000064); `CHK(cnt, 32'h00000064)
      lk(1'h1, TSW_OFF_CONTROL, 32'h00000002);
      lk(1'h1, TSW_OFF_CONTROL, 32'h00000003);
      // period is reload plus one, the zero count lasts a cycle
      for (int k = 0; k < 400 && cnt !== TSW_ZERO; k++) @(negedge i_clk);
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (cnt !== TSW_ZERO && n < 300);
      `CHK(n, 101)
      `CHK(irq, 1'h1)
      `CHK(sys_rst, 1'h0)
      @(negedge i_clk);
      `CHK(sys_rst, 1'h1)
      @(posedge i_clk);
      hw_reset();
      apb(1'h1, TSW_APB_GATE, TSW_ONE);
      lk(1'h1, TSW_OFF_RELOAD, TSW_ZERO);
      lk(1'h0, TSW_OFF_RAW, TSW_ZERO); `CHK(rd, TSW_ONE)
      lk(1'h0, TSW_OFF_MASKED, TSW_ZERO); `CHK(rd, TSW_ZERO)
      `CHK(irq, 1'h0)
      lk(1'h1, TSW_OFF_IRQ_CLR, TSW_ZERO);
      lk(1'h0, TSW_OFF_RAW, TSW_ZERO); `CHK(rd, TSW_ZERO)
      lk(1'h1, TSW_OFF_RELOAD, 32'h00000064);
      lk(1'h1, TSW_OFF_CONTROL, 32'h00000003);
      lk(1'h1, TSW_OFF_CONTROL, TSW_ZERO);
      lk(1'h0, TSW_OFF_CONTROL, TSW_ZERO); `CHK(rd, 32'h00000003)
      for (int k = 0; k < 400 && irq !== 1'h1; k++) @(negedge i_clk);
      `CHK(irq, 1'h1)
      @(posedge i_clk);
      lk(1'h1, TSW_OFF_RELOAD, 32'h00000064); `CHK(irq, 1'h1)
      lk(1'h1, TSW_OFF_IRQ_CLR, 32'h0000005A); `CHK(irq, 1'h0)
      `CHK(cnt > 32'h00000050, 1'h1)
      repeat (80) @(posedge i_clk);
      `CHK(sys_rst, 1'h0)
      lk(1'h1, TSW_OFF_LOCK, TSW_ZERO);
      lk(1'h1, TSW_OFF_LOCK, 32'h1ACCE550);
      lk(1'h0, TSW_OFF_LOCK, TSW_ZERO); `CHK(rd, TSW_ONE)
      lk(1'h1, TSW_OFF_RELOAD, 32'h00000005);
      lk(1'h0, TSW_OFF_RELOAD, TSW_ZERO); `CHK(rd, 32'h00000064)
      lk(1'h1, TSW_OFF_LOCK, TSW_UNLOCK_KEY);
      lk(1'h0, TSW_OFF_LOCK, TSW_ZERO); `CHK(rd, TSW_ZERO)
      lk(1'h1, TSW_OFF_RELOAD, TSW_ZERO);
      lk(1'h0, TSW_OFF_RAW, TSW_ZERO); `CHK(rd, TSW_ONE)
      lk(1'h0, TSW_OFF_MASKED, TSW_ZERO); `CHK(rd, TSW_ONE)
      test_done();
   end
endmodule : tb
